// >>> src/ecoh_pkg.sv
package ecoh_pkg;
  // ---------------------------------------------------------------
  // Frame identifiers and command bytes
  // ---------------------------------------------------------------
  localparam logic [10:0] ID_NMT    = 11'h000;
  localparam logic [10:0] ID_SYNC   = 11'h080;
  localparam logic [10:0] ID_TPDO2  = 11'h280;
  localparam logic [10:0] ID_SDO_TX = 11'h580;
  localparam logic [10:0] ID_SDO_RX = 11'h600;
  localparam logic [10:0] ID_BOOT   = 11'h700;
  localparam logic [7:0]  CS_DNLD   = 8'h22;
  localparam logic [7:0]  CS_ACK    = 8'h60;
  localparam logic [7:0]  CS_ABORT  = 8'h80;
  localparam logic [7:0]  NMT_START = 8'h01;
  localparam logic [7:0]  NMT_STOP  = 8'h02;
  localparam logic [7:0]  NMT_PREOP = 8'h80;
  localparam logic [7:0]  NMT_RNODE = 8'h81;
  localparam logic [7:0]  NMT_RCOMM = 8'h82;
  // ---------------------------------------------------------------
  // Objects, signature, abort codes
  // ---------------------------------------------------------------
  localparam logic [15:0] IDX_STORE  = 16'h1010;
  localparam logic [15:0] IDX_TTYPE  = 16'h1801;
  localparam logic [15:0] IDX_NODE   = 16'h3000;
  localparam logic [15:0] IDX_BAUD   = 16'h3001;
  localparam logic [15:0] IDX_MUR    = 16'h6001;
  localparam logic [15:0] IDX_RANGE  = 16'h6002;
  localparam logic [15:0] IDX_PRESET = 16'h6003;
  localparam logic [7:0]  SUB_VALUE  = 8'h00;
  localparam logic [7:0]  SUB_STORE  = 8'h01;
  localparam logic [7:0]  SUB_TTYPE  = 8'h02;
  localparam logic [31:0] SIG_SAVE   = 32'h65766173;
  localparam logic [31:0] ABT_CMD    = 32'h05040001;
  localparam logic [31:0] ABT_NOOBJ  = 32'h06020000;
  localparam logic [31:0] ABT_VALUE  = 32'h06090030;
  localparam logic [6:0]  NODE_ADD   = 7'h01;
  // ---------------------------------------------------------------
  // Frame fields, reset values, scaling
  // ---------------------------------------------------------------
  localparam int          B_IDX      = 8;
  localparam int          B_SUB      = 24;
  localparam int          B_VAL      = 32;
  localparam int          B_TGT      = 8;
  localparam int          RAW_FRAC   = 16;
  localparam logic [31:0] DEF_MUR    = 32'h00010000;
  localparam logic [31:0] DEF_RANGE  = 32'h00010000;
  localparam logic [7:0]  DEF_TTYPE  = 8'h01;
  // ---------------------------------------------------------------
  // Controller registers and timing
  // ---------------------------------------------------------------
  localparam logic [4:0]  REG_TGT    = 5'h00;
  localparam logic [4:0]  REG_OBJ    = 5'h04;
  localparam logic [4:0]  REG_VAL    = 5'h08;
  localparam logic [4:0]  REG_GO     = 5'h0c;
  localparam logic [4:0]  REG_STAT   = 5'h10;
  localparam logic [4:0]  REG_ANS    = 5'h14;
  localparam logic [4:0]  REG_POS    = 5'h18;
  localparam int          GO_SDO     = 0;
  localparam int          GO_SYNC    = 1;
  localparam int          GO_NMT     = 2;
  localparam int          CLK_PERIOD_NS = 100;
  localparam int          SDO_TMO_MS    = 10;
  localparam int          SDO_TMO_CYC   = SDO_TMO_MS * 1000000 / CLK_PERIOD_NS;

  typedef enum logic [1:0] {NS_BOOT, NS_PREOP, NS_OPER, NS_STOP} ecoh_nmt_t;

  function automatic logic [63:0] ecoh_sdo(input logic [7:0] cs, input logic [15:0] idx,
                                           input logic [7:0] sub, input logic [31:0] val);
    return {val, sub, idx, cs};
  endfunction
endpackage

// >>> src/ecoh_link_if.sv
`timescale 1ns/1ps
interface ecoh_link_if;
  logic        m2d_vld;
  logic [10:0] m2d_id;
  logic [63:0] m2d_data;
  logic        d2m_vld;
  logic [10:0] d2m_id;
  logic [63:0] d2m_data;
  modport dev (input m2d_vld, m2d_id, m2d_data, output d2m_vld, d2m_id, d2m_data);
  modport mst (output m2d_vld, m2d_id, m2d_data, input d2m_vld, d2m_id, d2m_data);
endinterface

// >>> src/ecoh_dev.sv
// How it works
// - Write request is 600h+node, command 22h.
// - Accepted write acknowledged 580h+node, command 60h.
// - Signature save at 1010h/01 persists configuration.
// - Node and baud changes wait for reset.
// - One revolution yields exactly configured step count.
// - Position wraps to zero at total range.
// - Master keeps range within rated maximum.
// - Preset write sets offset; position equals preset.
// - Master presets only while shaft stands still; ecoh_mst does not check shaft motion and sends a preset at any time.
// - Unstored offset lost at power cycle.
// - Transmission type 1 sends position every SYNC.
// - Position data only in operational state.
// - Master presets the two channels differently; here there is one position channel, preset by one SDO.
// - Effective node is configured value plus one.
// - Boot enters pre-operational, sends 700h+node frame.
//
// Decided for this implementation: the placing of the registers and strobed register access.
`timescale 1ns/1ps
module ecoh_dev import ecoh_pkg::*; (
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire logic        CE,
  ecoh_link_if.dev         lnk,
  input  wire logic [31:0] RAW_POS,
  input  wire logic [6:0]  NV_NODE,
  input  wire logic [7:0]  NV_BAUD,
  input  wire logic [31:0] NV_MUR,
  input  wire logic [31:0] NV_RANGE,
  input  wire logic [31:0] NV_OFFSET,
  input  wire logic [7:0]  NV_TTYPE,
  output ecoh_nmt_t        NMT_STATE,
  output logic      [6:0]  NODE_ID,
  output logic      [7:0]  BAUD_SEL,
  output logic      [31:0] POSITION,
  output logic             SV_STORE,
  output logic      [6:0]  SV_NODE,
  output logic      [7:0]  SV_BAUD,
  output logic      [31:0] SV_MUR,
  output logic      [31:0] SV_RANGE,
  output logic      [31:0] SV_OFFSET,
  output logic      [7:0]  SV_TTYPE
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    ecoh_nmt_t   nmt;
    logic [6:0]  node;
    logic [6:0]  node_pend;
    logic [7:0]  baud;
    logic [7:0]  baud_pend;
    logic [31:0] mur;
    logic [31:0] range;
    logic [31:0] offset;
    logic [7:0]  ttype;
    logic [7:0]  sync_cnt;
    logic [31:0] pos;
    logic        rep_pend;
    logic [63:0] rep_data;
    logic        pdo_pend;
    logic        store;
    logic        tx_vld;
    logic [10:0] tx_id;
    logic [63:0] tx_data;
  } ecoh_dev_st_t;

  localparam ecoh_dev_st_t DEV_RST = '{nmt: NS_BOOT, mur: DEF_MUR, range: DEF_RANGE,
                                       ttype: DEF_TTYPE, default: '0};

  ecoh_dev_st_t st_r;
  ecoh_dev_st_t st_nxt;

  logic [7:0]  cs;
  logic [15:0] idx;
  logic [7:0]  sub;
  logic [31:0] val;
  logic [31:0] cur;
  logic [31:0] pre;
  logic [31:0] code;
  logic        ok;
  logic [6:0]  tgt;

  // ---------------------------------------------------------------
  // Arithmetic
  // ---------------------------------------------------------------
  // Raw input carries RAW_FRAC fraction bits per turn, so the product
  // shifted back by RAW_FRAC gives whole configured steps per turn.
  function automatic logic [31:0] scale(input logic [31:0] raw, input logic [31:0] mur);
    logic [63:0] p;
    p = {32'h0, raw} * {32'h0, mur};
    return p[RAW_FRAC +: 32];
  endfunction

  function automatic logic [31:0] wrap(input logic [32:0] v, input logic [31:0] r);
    logic [32:0] m;
    m = (r == 32'h0) ? v : (v % {1'b0, r});
    return m[31:0];
  endfunction

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.tx_vld = 1'b0;
    st_nxt.store = 1'b0;
    cs = lnk.m2d_data[7:0];
    idx = lnk.m2d_data[B_IDX +: 16];
    sub = lnk.m2d_data[B_SUB +: 8];
    val = lnk.m2d_data[B_VAL +: 32];
    tgt = lnk.m2d_data[B_TGT +: 7];
    cur = wrap({1'b0, scale(RAW_POS, st_r.mur)}, st_r.range);
    pre = wrap({1'b0, val}, st_r.range);
    code = 32'h0;
    ok = 1'b1;
    st_nxt.pos = wrap({1'b0, cur} + {1'b0, st_r.offset}, st_r.range);

    // One frame out per cycle: reply first, position after.
    if (st_r.rep_pend) begin
      st_nxt.rep_pend = 1'b0;
      st_nxt.tx_vld = 1'b1;
      st_nxt.tx_id = ID_SDO_TX + {4'h0, st_r.node};
      st_nxt.tx_data = st_r.rep_data;
    end else if (st_r.pdo_pend && st_r.nmt == NS_OPER) begin
      st_nxt.pdo_pend = 1'b0;
      st_nxt.tx_vld = 1'b1;
      st_nxt.tx_id = ID_TPDO2 + {4'h0, st_r.node};
      st_nxt.tx_data = {32'h0, st_r.pos};
    end
    if (st_r.nmt != NS_OPER) begin
      st_nxt.pdo_pend = 1'b0;
    end

    case (st_r.nmt)
      NS_BOOT: begin
        // Stored node and baud (NV_NODE, NV_BAUD) become live only here.
        st_nxt.node = NV_NODE + NODE_ADD;
        st_nxt.node_pend = NV_NODE;
        st_nxt.baud = NV_BAUD;
        st_nxt.baud_pend = NV_BAUD;
        st_nxt.mur = NV_MUR;
        st_nxt.range = NV_RANGE;
        st_nxt.offset = NV_OFFSET;
        st_nxt.ttype = NV_TTYPE;
        st_nxt.sync_cnt = 8'h0;
        st_nxt.rep_pend = 1'b0;
        st_nxt.tx_vld = 1'b1;
        st_nxt.tx_id = ID_BOOT + {4'h0, NV_NODE + NODE_ADD};
        st_nxt.tx_data = 64'h0;
        st_nxt.nmt = NS_PREOP;
      end
      default: begin
        if (lnk.m2d_vld && lnk.m2d_id == ID_NMT &&
            (tgt == 7'h0 || tgt == st_r.node)) begin
          case (cs)
            NMT_START: st_nxt.nmt = NS_OPER;
            NMT_STOP:  st_nxt.nmt = NS_STOP;
            NMT_PREOP: st_nxt.nmt = NS_PREOP;
            NMT_RNODE: st_nxt.nmt = NS_BOOT;
            NMT_RCOMM: st_nxt.nmt = NS_BOOT;
            default:   st_nxt.nmt = st_r.nmt;
          endcase
        end else if (lnk.m2d_vld && lnk.m2d_id == ID_SYNC && st_r.nmt == NS_OPER &&
                     st_r.ttype != 8'h0) begin
          // Type n sends on every n-th SYNC; the default 1 sends on each.
          if (st_r.sync_cnt + 8'h1 >= st_r.ttype) begin
            st_nxt.sync_cnt = 8'h0;
            st_nxt.pdo_pend = 1'b1;
          end else begin
            st_nxt.sync_cnt = st_r.sync_cnt + 8'h1;
          end
        end else if (lnk.m2d_vld && lnk.m2d_id == ID_SDO_RX + {4'h0, st_r.node} &&
                     st_r.nmt != NS_STOP) begin
          if (cs != CS_DNLD) begin
            ok = 1'b0;
            code = ABT_CMD;
          end else begin
            case (idx)
              IDX_STORE: begin
                if (sub != SUB_STORE) begin
                  ok = 1'b0;
                  code = ABT_NOOBJ;
                end else if (val != SIG_SAVE) begin
                  ok = 1'b0;
                  code = ABT_VALUE;
                end else begin
                  st_nxt.store = 1'b1;
                end
              end
              IDX_NODE: begin
                if (sub == SUB_VALUE) st_nxt.node_pend = val[6:0];
                else begin
                  ok = 1'b0;
                  code = ABT_NOOBJ;
                end
              end
              IDX_BAUD: begin
                if (sub == SUB_VALUE) st_nxt.baud_pend = val[7:0];
                else begin
                  ok = 1'b0;
                  code = ABT_NOOBJ;
                end
              end
              IDX_MUR, IDX_RANGE: begin
                // Zero would stall scaling or wrapping, so it is refused.
                if (sub != SUB_VALUE) begin
                  ok = 1'b0;
                  code = ABT_NOOBJ;
                end else if (val == 32'h0) begin
                  ok = 1'b0;
                  code = ABT_VALUE;
                end else if (idx == IDX_MUR) begin
                  st_nxt.mur = val;
                end else begin
                  st_nxt.range = val;
                  st_nxt.offset = 32'h0;
                end
              end
              IDX_PRESET: begin
                // Offset taken against this cycle's shaft reading.
                if (sub == SUB_VALUE) begin
                  st_nxt.offset = wrap({1'b0, pre} + {1'b0, st_r.range} - {1'b0, cur},
                                       st_r.range);
                end else begin
                  ok = 1'b0;
                  code = ABT_NOOBJ;
                end
              end
              IDX_TTYPE: begin
                if (sub == SUB_TTYPE) begin
                  st_nxt.ttype = val[7:0];
                  st_nxt.sync_cnt = 8'h0;
                end else begin
                  ok = 1'b0;
                  code = ABT_NOOBJ;
                end
              end
              default: begin
                ok = 1'b0;
                code = ABT_NOOBJ;
              end
            endcase
          end
          st_nxt.rep_pend = 1'b1;
          st_nxt.rep_data = ok ? ecoh_sdo(CS_ACK, idx, sub, 32'h0)
                               : ecoh_sdo(CS_ABORT, idx, sub, code);
        end
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (RST) begin
      st_r <= DEV_RST;
    end else if (CE) begin
      st_r <= st_nxt;
    end
  end

  assign lnk.d2m_vld = st_r.tx_vld;
  assign lnk.d2m_id = st_r.tx_id;
  assign lnk.d2m_data = st_r.tx_data;
  assign NMT_STATE = st_r.nmt;
  assign NODE_ID = st_r.node;
  assign BAUD_SEL = st_r.baud;
  assign POSITION = st_r.pos;
  assign SV_STORE = st_r.store;
  assign SV_NODE = st_r.node_pend;
  assign SV_BAUD = st_r.baud_pend;
  assign SV_MUR = st_r.mur;
  assign SV_RANGE = st_r.range;
  assign SV_OFFSET = st_r.offset;
  assign SV_TTYPE = st_r.ttype;
endmodule

// >>> src/ecoh_mst.sv
`timescale 1ns/1ps
module ecoh_mst import ecoh_pkg::*; #(
  parameter int          TMO_CYC   = SDO_TMO_CYC,
  parameter logic [31:0] MAX_RANGE = 32'h01000000
) (
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire logic        CE,
  ecoh_link_if.mst         lnk,
  input  wire logic [4:0]  ADDR,
  input  wire logic [31:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [31:0] RDATA
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [6:0]  tgt;
    logic [23:0] obj;
    logic [31:0] val;
    logic        busy;
    logic        done;
    logic        abrt;
    logic        tmo;
    logic        refused;
    logic        boot;
    logic [31:0] ans;
    logic [31:0] pos;
    logic [23:0] tmr;
    logic [31:0] rdata;
    logic        tx_vld;
    logic [10:0] tx_id;
    logic [63:0] tx_data;
  } ecoh_mst_st_t;

  localparam logic [23:0] TMO_LAST = 24'(TMO_CYC - 1);

  ecoh_mst_st_t st_r;
  ecoh_mst_st_t st_nxt;
  logic [5:0]   stat;
  logic         rsp_hit;

  always_comb begin
    st_nxt = st_r;
    st_nxt.tx_vld = 1'b0;
    st_nxt.rdata = 32'h0;
    stat = {st_r.boot, st_r.refused, st_r.tmo, st_r.abrt, st_r.done, st_r.busy};
    rsp_hit = st_r.busy && lnk.d2m_vld && lnk.d2m_id == ID_SDO_TX + {4'h0, st_r.tgt};
    // ---------------------------------------------------------------
    // Register port; sticky flags clear by writing one, set wins below
    // ---------------------------------------------------------------
    if (WR) begin
      case (ADDR)
        REG_TGT: st_nxt.tgt = WDATA[6:0];
        REG_OBJ: st_nxt.obj = WDATA[23:0];
        REG_VAL: st_nxt.val = WDATA;
        REG_STAT: begin
          st_nxt.done = st_r.done & ~WDATA[1];
          st_nxt.abrt = st_r.abrt & ~WDATA[2];
          st_nxt.tmo = st_r.tmo & ~WDATA[3];
          st_nxt.refused = st_r.refused & ~WDATA[4];
          st_nxt.boot = st_r.boot & ~WDATA[5];
        end
        REG_GO: begin
          if (WDATA[GO_SDO]) begin
            // Out-of-rating ranges never reach the bus.
            if (st_r.busy || (st_r.obj[15:0] == IDX_RANGE && st_r.val > MAX_RANGE)) begin
              st_nxt.refused = 1'b1;
            end else begin
              st_nxt.busy = 1'b1;
              st_nxt.tmr = 24'h0;
              st_nxt.tx_vld = 1'b1;
              st_nxt.tx_id = ID_SDO_RX + {4'h0, st_r.tgt};
              st_nxt.tx_data = ecoh_sdo(CS_DNLD, st_r.obj[15:0], st_r.obj[23:16], st_r.val);
            end
          end else if (WDATA[GO_SYNC]) begin
            st_nxt.tx_vld = 1'b1;
            st_nxt.tx_id = ID_SYNC;
            st_nxt.tx_data = 64'h0;
          end else if (WDATA[GO_NMT]) begin
            st_nxt.tx_vld = 1'b1;
            st_nxt.tx_id = ID_NMT;
            st_nxt.tx_data = {48'h0, 1'b0, st_r.tgt, st_r.val[7:0]};
          end
        end
        default: st_nxt.tgt = st_r.tgt;
      endcase
    end
    if (RD) begin
      case (ADDR)
        REG_TGT:  st_nxt.rdata = {25'h0, st_r.tgt};
        REG_OBJ:  st_nxt.rdata = {8'h0, st_r.obj};
        REG_VAL:  st_nxt.rdata = st_r.val;
        REG_STAT: st_nxt.rdata = {26'h0, stat};
        REG_ANS:  st_nxt.rdata = st_r.ans;
        REG_POS:  st_nxt.rdata = st_r.pos;
        default:  st_nxt.rdata = 32'h0;
      endcase
    end
    // ---------------------------------------------------------------
    // Link receive
    // ---------------------------------------------------------------
    if (st_r.busy) begin
      st_nxt.tmr = st_r.tmr + 24'h1;
      // Reply in the last cycle beats the timeout, so no clear is undone
      if (st_r.tmr == TMO_LAST && !rsp_hit) begin
        st_nxt.busy = 1'b0;
        st_nxt.tmo = 1'b1;
      end
    end
    if (lnk.d2m_vld) begin
      if (rsp_hit) begin
        st_nxt.busy = 1'b0;
        st_nxt.ans = lnk.d2m_data[B_VAL +: 32];
        if (lnk.d2m_data[7:0] == CS_ACK) st_nxt.done = 1'b1;
        else st_nxt.abrt = 1'b1;
      end else if (lnk.d2m_id == ID_TPDO2 + {4'h0, st_r.tgt}) begin
        st_nxt.pos = lnk.d2m_data[31:0];
      end else if (lnk.d2m_id == ID_BOOT + {4'h0, st_r.tgt}) begin
        st_nxt.boot = 1'b1;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      st_r <= '0;
    end else if (CE) begin
      st_r <= st_nxt;
    end
  end

  assign lnk.m2d_vld = st_r.tx_vld;
  assign lnk.m2d_id = st_r.tx_id;
  assign lnk.m2d_data = st_r.tx_data;
  assign RDATA = st_r.rdata;
endmodule

// >>> sim/ecoh_assertions.sv
`timescale 1ns/1ps
module ecoh_assertions import ecoh_pkg::*; (
  input wire logic        CLK,
  input wire logic        RST,
  input wire logic        m2d_vld,
  input wire logic [10:0] m2d_id,
  input wire logic [63:0] m2d_data,
  input wire logic        d2m_vld,
  input wire logic [10:0] d2m_id,
  input wire logic [63:0] d2m_data
);
  // ---------------------------------------------------------------
  // Frame classes
  // ---------------------------------------------------------------
  logic sdo_req;
  logic sdo_rsp;
  logic boot_f;
  assign sdo_req = m2d_vld && (m2d_id[10:7] == 4'hc);
  assign sdo_rsp = d2m_vld && (d2m_id[10:7] == 4'hb);
  assign boot_f  = d2m_vld && (d2m_id[10:7] == 4'he);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_reply_id_echo: assert property (
    sdo_req |-> ##2 (sdo_rsp && d2m_id == $past(m2d_id, 2) - 11'h080))
    else $error("reply id wrong or late");
  a_reply_obj_echo: assert property (
    sdo_req |-> ##2 (d2m_data[31:8] == $past(m2d_data[31:8], 2)))
    else $error("reply object not echoed");
  a_reply_code: assert property (
    sdo_req |-> ##2 (d2m_data[7:0] == CS_ACK || d2m_data[7:0] == CS_ABORT))
    else $error("reply command byte wrong");
  a_ack_zero_data: assert property (
    sdo_rsp && d2m_data[7:0] == CS_ACK |-> d2m_data[63:32] == 32'h0)
    else $error("ack data not zero");
  a_no_stray_reply: assert property (
    sdo_rsp |-> $past(sdo_req, 2))
    else $error("reply without request");
  a_bad_signature: assert property (
    sdo_req && m2d_data[31:8] == {SUB_STORE, IDX_STORE} && m2d_data[63:32] != SIG_SAVE
    |-> ##2 (d2m_data == {ABT_VALUE, SUB_STORE, IDX_STORE, CS_ABORT}))
    else $error("bad signature not aborted");
  a_save_acked: assert property (
    sdo_req && m2d_data == {SIG_SAVE, SUB_STORE, IDX_STORE, CS_DNLD}
    |-> ##2 (d2m_data[7:0] == CS_ACK))
    else $error("store not acknowledged");
  a_boot_frame_data: assert property (
    boot_f |-> d2m_data == 64'h0)
    else $error("boot frame data not zero");
  a_boot_after_reset: assert property (
    $fell(RST) |-> ##[1:3] boot_f)
    else $error("no boot frame after reset");
endmodule

// >>> sim/tb_encoder_config_object_handler.sv
`timescale 1ns/1ps
module tb_encoder_config_object_handler import ecoh_pkg::*;;
  logic clk, rst, ce, wr, rd, sv_store;
  logic [4:0]  addr;
  logic [31:0] wdata, rdata, raw_pos, nv_mur, nv_range, nv_offset, position;
  logic [31:0] sv_mur, sv_range, sv_offset, d;
  logic [6:0]  nv_node, node_id, sv_node;
  logic [7:0]  nv_baud, nv_ttype, baud_sel, sv_baud, sv_ttype;
  logic [10:0] last_id;
  ecoh_nmt_t   nmt_state;
  int errors, n_compared, pdo_cnt, boot_cnt, store_cnt, k;
  ecoh_link_if u_ecoh_link_if ();
  ecoh_dev u_ecoh_dev (.CLK(clk), .RST(rst), .CE(ce), .lnk(u_ecoh_link_if),
    .RAW_POS(raw_pos), .NV_NODE(nv_node), .NV_BAUD(nv_baud), .NV_MUR(nv_mur),
    .NV_RANGE(nv_range), .NV_OFFSET(nv_offset), .NV_TTYPE(nv_ttype), .NMT_STATE(nmt_state),
    .NODE_ID(node_id), .BAUD_SEL(baud_sel), .POSITION(position), .SV_STORE(sv_store),
    .SV_NODE(sv_node), .SV_BAUD(sv_baud), .SV_MUR(sv_mur), .SV_RANGE(sv_range),
    .SV_OFFSET(sv_offset), .SV_TTYPE(sv_ttype));
  ecoh_mst #(.TMO_CYC(50)) u_ecoh_mst (.CLK(clk), .RST(rst), .CE(ce), .lnk(u_ecoh_link_if),
    .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata));
  ecoh_assertions u_ecoh_assertions (.CLK(clk), .RST(rst),
    .m2d_vld(u_ecoh_link_if.m2d_vld), .m2d_id(u_ecoh_link_if.m2d_id),
    .m2d_data(u_ecoh_link_if.m2d_data), .d2m_vld(u_ecoh_link_if.d2m_vld),
    .d2m_id(u_ecoh_link_if.d2m_id), .d2m_data(u_ecoh_link_if.d2m_data));
  // ---------------------------------------------------------------
  // Clock and stored image
  // ---------------------------------------------------------------
  initial clk = 1'b0;
  always #(CLK_PERIOD_NS / 2) clk = ~clk;
  // Bench plays the nonvolatile store, so a reboot shows what was persisted
  always @(posedge clk) begin
    if (u_ecoh_link_if.d2m_vld) begin
      last_id <= u_ecoh_link_if.d2m_id;
      if (u_ecoh_link_if.d2m_id[10:7] == 4'h5) pdo_cnt <= pdo_cnt + 1;
      if (u_ecoh_link_if.d2m_id[10:7] == 4'he) boot_cnt <= boot_cnt + 1;
    end
    if (sv_store === 1'b1) begin
      store_cnt <= store_cnt + 1;
      nv_node   <= sv_node;
      nv_baud   <= sv_baud;
      nv_mur    <= sv_mur;
      nv_range  <= sv_range;
      nv_offset <= sv_offset;
      nv_ttype  <= sv_ttype;
    end
  end
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr_reg(input logic [4:0] a, input logic [31:0] v);
    @(posedge clk);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [4:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic sdo(input logic [15:0] ix, input logic [7:0] sb, input logic [31:0] v,
                     input logic [31:0] est, input logic [31:0] eans);
    logic [31:0] s;
    wr_reg(REG_OBJ, {8'h00, sb, ix});
    wr_reg(REG_VAL, v);
    wr_reg(REG_GO, 32'h1);
    s = 32'h1;
    for (int j = 0; j < 40 && s[0] !== 1'b0; j++) rd_reg(REG_STAT, s);
    chk("status", est, s & 32'h1e);
    rd_reg(REG_ANS, s);
    chk("answer", eans, s);
    wr_reg(REG_STAT, 32'h3e);
  endtask
  task automatic send_sync(input int n);
    wr_reg(REG_GO, 32'h2);
    for (int j = 0; j < 20 && pdo_cnt < n; j++) @(posedge clk);
  endtask
  task automatic nmt(input logic [7:0] c);
    wr_reg(REG_VAL, {24'h0, c});
    wr_reg(REG_GO, 32'h4);
    repeat (10) @(posedge clk);
  endtask
  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    stop_test();
  end
  initial begin
    {rst, ce, wr, rd, addr, wdata, raw_pos} = {1'b1, 1'b1, 1'b0, 1'b0, 5'h00, 32'h0, 32'h0};
    {nv_node, nv_baud, nv_offset, nv_ttype} = {7'h0a, 8'h03, 32'h0, DEF_TTYPE};
    {nv_mur, nv_range} = {DEF_MUR, DEF_RANGE};
    {errors, n_compared, pdo_cnt, boot_cnt, store_cnt} = '0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    for (k = 0; k < 30 && boot_cnt < 1; k++) @(posedge clk);
    chk("node id", 32'h0b, 32'(node_id));
    chk("state", 32'(NS_PREOP), 32'(nmt_state));
    chk("boot id", 32'h70b, 32'(last_id));
    wr_reg(REG_TGT, 32'h0b);
    // Boot flag only counts frames of the target node, so reboot once more
    nmt(NMT_RCOMM);
    chk("reboot count", 32'h2, 32'(boot_cnt));
    rd_reg(REG_STAT, d);
    chk("boot seen", 32'h20, d & 32'h20);
    $display("test boot done");
    sdo(IDX_NODE, SUB_VALUE, 32'h5, 32'h2, 32'h0);
    sdo(IDX_BAUD, SUB_VALUE, 32'h7, 32'h2, 32'h0);
    chk("node kept", 32'h0b, 32'(node_id));
    chk("baud kept", 32'h03, 32'(baud_sel));
    chk("node pending", 32'h05, 32'(sv_node));
    $display("test network settings done");
    sdo(IDX_MUR, SUB_VALUE, 32'd3600, 32'h2, 32'h0);
    raw_pos <= 32'h18000;
    repeat (3) @(posedge clk);
    chk("scaled", 32'd5400, position);
    sdo(IDX_RANGE, SUB_VALUE, 32'd7200, 32'h2, 32'h0);
    raw_pos <= 32'h1ffff;
    repeat (3) @(posedge clk);
    chk("top of range", 32'd7199, position);
    raw_pos <= 32'h28000;
    repeat (3) @(posedge clk);
    chk("wrapped", 32'd1800, position);
    sdo(IDX_RANGE, SUB_VALUE, 32'h01000001, 32'h10, 32'h0);
    chk("range kept", 32'd7200, sv_range);
    $display("test scaling done");
    raw_pos <= 32'h18000;
    sdo(IDX_PRESET, SUB_VALUE, 32'd10, 32'h2, 32'h0);
    chk("preset", 32'd10, position);
    ce      <= 1'b0;
    raw_pos <= 32'h20000;
    repeat (3) @(posedge clk);
    chk("frozen", 32'd10, position);
    ce <= 1'b1;
    repeat (3) @(posedge clk);
    chk("preset moved", 32'd1810, position);
    raw_pos <= 32'h18000;
    $display("test preset done");
    sdo(IDX_STORE, SUB_STORE, 32'h65766174, 32'h4, ABT_VALUE);
    sdo(16'h6004, SUB_VALUE, 32'h1, 32'h4, ABT_NOOBJ);
    sdo(IDX_PRESET, 8'h01, 32'h3, 32'h4, ABT_NOOBJ);
    sdo(IDX_RANGE, SUB_VALUE, 32'h0, 32'h4, ABT_VALUE);
    chk("no store", 32'h0, 32'(store_cnt));
    chk("offset kept", 32'd10, position);
    sdo(IDX_STORE, SUB_STORE, SIG_SAVE, 32'h2, 32'h0);
    chk("stored", 32'h1, 32'(store_cnt));
    chk("offset saved", 32'd1810, sv_offset);
    $display("test store done");
    send_sync(1);
    chk("no pdo in preop", 32'h0, 32'(pdo_cnt));
    nmt(NMT_START);
    chk("operational", 32'(NS_OPER), 32'(nmt_state));
    send_sync(1);
    rd_reg(REG_POS, d);
    chk("pdo position", 32'd10, d);
    sdo(IDX_TTYPE, SUB_TTYPE, 32'h2, 32'h2, 32'h0);
    send_sync(2);
    chk("first of two", 32'h1, 32'(pdo_cnt));
    send_sync(2);
    chk("second of two", 32'h2, 32'(pdo_cnt));
    nmt(NMT_STOP);
    chk("stopped", 32'(NS_STOP), 32'(nmt_state));
    send_sync(3);
    chk("no pdo stopped", 32'h2, 32'(pdo_cnt));
    nmt(NMT_PREOP);
    chk("preop again", 32'(NS_PREOP), 32'(nmt_state));
    $display("test sync done");
    nmt(NMT_RNODE);
    for (k = 0; k < 30 && boot_cnt < 3; k++) @(posedge clk);
    chk("new node", 32'h06, 32'(node_id));
    chk("new baud", 32'h07, 32'(baud_sel));
    chk("reboot id", 32'h706, 32'(last_id));
    chk("offset restored", 32'd10, position);
    wr_reg(REG_TGT, 32'h06);
    sdo(IDX_PRESET, SUB_VALUE, 32'd20, 32'h2, 32'h0);
    chk("preset new node", 32'd20, position);
    $display("test reboot done");
    stop_test();
  end
endmodule
